/* File: core/pmr_regs.svh */
`ifndef PMR_REGS_SVH
`define PMR_REGS_SVH

// Register indices; byte address is four times the index
`define PMR_IDX_POWER_CONTROL_REG        8'h87
`define PMR_IDX_POR_KILL    8'hFD
`define PMR_IDX_LVR_KILL    8'hFF
`define PMR_IDX_SAG0        8'hA3
`define PMR_IDX_SAG1        8'hAB
`define PMR_IDX_CFG2        8'h90
`define PMR_IDX_CAUSE       8'h91
`define PMR_IDX_UNLOCK      8'hC7

// Field positions
`define PMR_POWER_CONTROL_REG_COLD       4
`define PMR_SAG0_EN         7
`define PMR_SAG0_THR_HI     6
`define PMR_SAG0_THR_LO     4
`define PMR_SAG0_FLAG       3
`define PMR_SAG0_RSTEN      2
`define PMR_SAG0_RSTF       1
`define PMR_SAG0_LIVE       0
`define PMR_SAG1_LP_HI      2
`define PMR_SAG1_LP_LO      1
`define PMR_SAG1_FLT        0
`define PMR_CFG_EN          7
`define PMR_CFG_THR_HI      6
`define PMR_CFG_THR_LO      4
`define PMR_CFG_RSTEN       2

// Reset values
`define PMR_POWER_CONTROL_REG_RST        8'h10
`define PMR_CFG2_RST        8'hFF
`define PMR_SAG1_RST        8'h01
`define PMR_RESET_VECTOR    16'h0000

// Key values
`define PMR_KILL_KEY1       8'h5A
`define PMR_KILL_KEY2       8'hA5
`define PMR_UNLOCK_KEY1     8'hAA
`define PMR_UNLOCK_KEY2     8'h55

// Timing
`define PMR_RST_HOLD_CYC    16
`define PMR_SETTLE_TICKS    3
`define PMR_FLT_FAST_CYC    32
`define PMR_FLT_SLOW_TICKS  2
`define PMR_SLOW_OSC_HZ     10000
`define PMR_LP1_PERIOD_US   1600
`define PMR_LP2_PERIOD_US   6400
`define PMR_LP3_PERIOD_US   25600

`endif

/* File: core/pmr_pkg.sv */
package pmr_pkg;

  typedef enum logic [1:0] {
    PMR_ST_COLD = 2'b00,
    PMR_ST_RUN  = 2'b01,
    PMR_ST_WARM = 2'b11
  } pmr_state_t;

  typedef struct packed {
    pmr_state_t  st;
    logic [7:0]  hold;
    logic [7:0]  power_control_reg;
    logic [7:0]  cfg;
    logic        sag_en;
    logic [2:0]  sag_thr;
    logic        sag_flag;
    logic        sag_rsten;
    logic        sag_rstf;
    logic [1:0]  lp_sel;
    logic        flt_en;
    logic [2:0]  cause;
    logic        ta_stage;
    logic        ta_open;
    logic        live;
    logic        en_seen;
    logic [1:0]  settle;
    logic        settled;
    logic [8:0]  lp_cnt;
    logic        sample;
    logic        sense_on;
    logic        osc_en;
    logic [7:0]  rdata;
  } pmr_core_t;

  typedef struct packed {
    logic armed;
    logic killed;
  } pmr_kill_t;

  typedef struct packed {
    logic       out;
    logic [5:0] cnt;
  } pmr_flt_t;

endpackage

/* File: core/pmr_kill_seq.sv */
`timescale 1ns/100ps
`include "pmr_regs.svh"

module pmr_kill_seq (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       key_wr,
  input  wire logic       other_wr,
  input  wire logic [7:0] wdata,
  output logic            killed
);

  pmr_pkg::pmr_kill_t r;
  pmr_pkg::pmr_kill_t n;

  always_comb begin
    n = r;
    if (key_wr) begin
      n.armed = 1'b0;
      if (wdata == `PMR_KILL_KEY1) begin
        n.armed = 1'b1;
      end else if (r.armed && wdata == `PMR_KILL_KEY2) begin
        n.killed = 1'b1;
      end
    end else if (other_wr) begin
      // Any other accepted write between the keys, except to the unlock register, breaks the pair
      n.armed = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{armed: 1'b0, killed: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign killed = r.killed;

endmodule // pmr_kill_seq

/* File: core/pmr_glitch_filter.sv */
`timescale 1ns/100ps
`include "pmr_regs.svh"

module pmr_glitch_filter #(
  parameter int FAST_CYC   = `PMR_FLT_FAST_CYC,
  parameter int SLOW_TICKS = `PMR_FLT_SLOW_TICKS
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  input  wire logic enable,
  input  wire logic use_fast,
  input  wire logic slow_tick,
  output logic      dout
);

  pmr_pkg::pmr_flt_t r;
  pmr_pkg::pmr_flt_t n;
  logic              step;
  logic [5:0]        last;

  assign step = use_fast | slow_tick;
  assign last = use_fast ? 6'(FAST_CYC - 1) : 6'(SLOW_TICKS - 1);

  always_comb begin
    n = r;
    if (!enable) begin
      n.out = din;
      n.cnt = 6'h00;
    end else if (din == r.out) begin
      n.cnt = 6'h00;
    end else if (step) begin
      // Output follows only after the input held steady for the full count
      if (r.cnt >= last) begin
        n.out = din;
        n.cnt = 6'h00;
      end else begin
        n.cnt = r.cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{out: 1'b0, cnt: 6'h00};
    end else begin
      r <= n;
    end
  end

  assign dout = r.out;

endmodule // pmr_glitch_filter

/* File: core/pmr_power_reset_ctrl.sv */
// Our own choice: the APB slave port.
`timescale 1ns/100ps
`include "pmr_regs.svh"

// Behaviour
// - Six reset sources return CPU to reset
// - Registers reset; sag control 1 and cause flags depend
// - Hold CPU while supply low; start at 0000H
// - Power-on completion sets cold-start flag
// - Cold flag survives warm resets; writable
// - 5A then A5 kills power-on detector
// - 5A then A5 kills low-voltage detector
// - Sag control 0 writes need open window
// - Eight thresholds, codes from config field
// - Software may change threshold select field
// - Ignore detector for 2-3 slow ticks
// - Drop without reset enable sets event flag
// - No re-set without a new crossing
// - Recovery above threshold also sets flag
// - Read-only live status at bit 0
// - Reset enable turns drop into reset
// - Sag reset sets flag; POR or write clears
// - Periodic sensing at 1.6, 6.4, 25.6 ms
// - Glitch filter on after POR; writable off
// - Config word: enable bit 7, reset bit 2
// - Event flag reset value from config, supply
// - Every reset reloads control 0 from config
// - Live status 1 only below, when enabled
// - Code 00 always on; else periodic modes
// - Filter 32 fast clocks or 2 slow ticks

module pmr_power_reset_ctrl #(
  parameter int ADDR_W   = 10,
  parameter int RST_HOLD = `PMR_RST_HOLD_CYC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              por_supply_low,
  input  wire logic              lvr_supply_low,
  input  wire logic              ext_rst_req,
  input  wire logic              wdt_rst_req,
  input  wire logic              sw_rst_req,
  input  wire logic              supply_below,
  input  wire logic              slow_osc_tick,
  input  wire logic              sys_clk_fast_src,
  input  wire logic              power_down,
  output logic                   cpu_rst_n,
  output logic                   osc_start,
  output logic [15:0]            reset_vector,
  output logic                   sag_sense_on,
  output logic [2:0]             sag_threshold_select,
  output logic                   sag_irq_req,
  output logic                   por_circuit_off,
  output logic                   lvr_circuit_off
);

  localparam int LP1_TICKS = `PMR_LP1_PERIOD_US * `PMR_SLOW_OSC_HZ / 1000000;
  localparam int LP2_TICKS = `PMR_LP2_PERIOD_US * `PMR_SLOW_OSC_HZ / 1000000;
  localparam int LP3_TICKS = `PMR_LP3_PERIOD_US * `PMR_SLOW_OSC_HZ / 1000000;
  localparam logic [7:0] SAG1_RST = `PMR_SAG1_RST;
  localparam pmr_pkg::pmr_core_t CORE_RST = '{
    st:        pmr_pkg::PMR_ST_COLD,
    hold:      8'(RST_HOLD),
    power_control_reg:      `PMR_POWER_CONTROL_REG_RST,
    cfg:       `PMR_CFG2_RST,
    sag_en:    1'b0,
    sag_thr:   3'h0,
    sag_flag:  1'b0,
    sag_rsten: 1'b0,
    sag_rstf:  1'b0,
    lp_sel:    2'h0,
    flt_en:    1'b1,
    cause:     3'h0,
    ta_stage:  1'b0,
    ta_open:   1'b0,
    live:      1'b0,
    en_seen:   1'b0,
    settle:    2'h0,
    settled:   1'b0,
    lp_cnt:    9'h000,
    sample:    1'b0,
    sense_on:  1'b0,
    osc_en:    1'b0,
    rdata:     8'h00
  };

  function automatic logic pmr_mapped(input logic [7:0] idx);
    pmr_mapped = (idx == `PMR_IDX_POWER_CONTROL_REG)     || (idx == `PMR_IDX_POR_KILL) ||
                 (idx == `PMR_IDX_LVR_KILL) || (idx == `PMR_IDX_SAG0)     ||
                 (idx == `PMR_IDX_SAG1)     || (idx == `PMR_IDX_CFG2)     ||
                 (idx == `PMR_IDX_CAUSE)    || (idx == `PMR_IDX_UNLOCK);
  endfunction

  function automatic logic pmr_protected(input logic [7:0] idx);
    pmr_protected = (idx == `PMR_IDX_POR_KILL) || (idx == `PMR_IDX_LVR_KILL) ||
                    (idx == `PMR_IDX_SAG0)     || (idx == `PMR_IDX_SAG1)     ||
                    (idx == `PMR_IDX_CFG2);
  endfunction

  function automatic logic [8:0] pmr_lp_last(input logic [1:0] sel);
    unique case (sel)
      2'b01:   pmr_lp_last = 9'(LP1_TICKS - 1);
      2'b10:   pmr_lp_last = 9'(LP2_TICKS - 1);
      2'b11:   pmr_lp_last = 9'(LP3_TICKS - 1);
      2'b00:   pmr_lp_last = 9'h000;
    endcase
  endfunction

  pmr_pkg::pmr_core_t r;
  pmr_pkg::pmr_core_t n;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic       access;
  logic       hit;
  logic       wr;
  logic       wr_ok;
  logic       other_wr;
  logic       por_killed;
  logic       lvr_killed;
  logic       filt_below;
  logic       cold_src;
  logic       warm_src;
  logic       valid;
  logic       live_n;
  logic       drop;
  logic       rec;
  logic       use_fast;

  assign idx    = paddr[9:2];
  assign wdata  = pwdata[7:0];
  assign access = psel & penable;
  assign hit    = (paddr[1:0] == 2'b00) & pmr_mapped(idx);
  assign wr     = access & pwrite & hit & pstrb[0];
  assign wr_ok  = wr & (~pmr_protected(idx) | r.ta_open);
  assign other_wr = wr_ok & (idx != `PMR_IDX_UNLOCK);

  pmr_kill_seq u_por_kill (
    .pclk     (pclk),
    .presetn  (presetn),
    .key_wr   (wr_ok & (idx == `PMR_IDX_POR_KILL)),
    .other_wr (other_wr & (idx != `PMR_IDX_POR_KILL)),
    .wdata    (wdata),
    .killed   (por_killed)
  );

  pmr_kill_seq u_lvr_kill (
    .pclk     (pclk),
    .presetn  (presetn),
    .key_wr   (wr_ok & (idx == `PMR_IDX_LVR_KILL)),
    .other_wr (other_wr & (idx != `PMR_IDX_LVR_KILL)),
    .wdata    (wdata),
    .killed   (lvr_killed)
  );

  // Fast count only in always-on mode on a fast clock
  assign use_fast = sys_clk_fast_src & ~power_down & (r.lp_sel == 2'b00);
  // Filter steered by its enable bit
  pmr_glitch_filter u_filter (
    .pclk      (pclk),
    .presetn   (presetn),
    .din       (r.sample),
    .enable    (r.flt_en),
    .use_fast  (use_fast),
    .slow_tick (slow_osc_tick),
    .dout      (filt_below)
  );

  assign valid  = r.sag_en & r.settled;
  assign live_n = valid & filt_below;
  assign drop   = live_n & ~r.live;
  assign rec    = ~live_n & r.live & valid;

  // Supply low holds power-on class reset
  assign cold_src = (por_supply_low & ~por_killed) | (lvr_supply_low & ~lvr_killed);
  // Warm sources, sag held while below
  assign warm_src = ext_rst_req | wdt_rst_req | sw_rst_req | (drop & r.sag_rsten) |
                    (r.live & r.sag_rsten);

  always_comb begin
    n = r;
    n.osc_en = (r.st == pmr_pkg::PMR_ST_RUN);

    // Read data is latched in the setup phase
    if (psel && !penable) begin
      n.rdata = 8'h00;
      if (hit) begin
        unique case (idx)
          `PMR_IDX_POWER_CONTROL_REG:   n.rdata = r.power_control_reg;
          `PMR_IDX_SAG0:   n.rdata = {r.sag_en, r.sag_thr, r.sag_flag, r.sag_rsten,
                                      r.sag_rstf, r.live};
          `PMR_IDX_SAG1:   n.rdata = {5'h00, r.lp_sel, r.flt_en};
          `PMR_IDX_CFG2:   n.rdata = r.cfg;
          `PMR_IDX_CAUSE:  n.rdata = {5'h00, r.cause};
          `PMR_IDX_UNLOCK: n.rdata = {7'h00, r.ta_open};
          default:         n.rdata = 8'h00;
        endcase
      end
    end

    if (wr && idx == `PMR_IDX_UNLOCK) begin
      n.ta_stage = (wdata == `PMR_UNLOCK_KEY1);
      if (r.ta_stage && wdata == `PMR_UNLOCK_KEY2) begin
        n.ta_open = 1'b1;
      end
    end
    if (wr && pmr_protected(idx)) begin
      n.ta_open  = 1'b0;
      n.ta_stage = 1'b0;
    end

    if (wr_ok) begin
      unique case (idx)
        // Software may clear the cold flag
        `PMR_IDX_POWER_CONTROL_REG: n.power_control_reg = wdata;
        `PMR_IDX_SAG0: begin
          n.sag_en    = wdata[`PMR_SAG0_EN];
          n.sag_thr   = wdata[`PMR_SAG0_THR_HI:`PMR_SAG0_THR_LO];
          n.sag_flag  = wdata[`PMR_SAG0_FLAG];
          n.sag_rsten = wdata[`PMR_SAG0_RSTEN];
          n.sag_rstf  = wdata[`PMR_SAG0_RSTF];
        end
        `PMR_IDX_SAG1: begin
          n.lp_sel = wdata[`PMR_SAG1_LP_HI:`PMR_SAG1_LP_LO];
          n.flt_en = wdata[`PMR_SAG1_FLT];
        end
        `PMR_IDX_CFG2:  n.cfg   = wdata;
        `PMR_IDX_CAUSE: n.cause = wdata[2:0];
        default: ;
      endcase
    end

    // Reset sequencing
    unique case (r.st)
      pmr_pkg::PMR_ST_RUN: begin
        if (warm_src) begin
          n.st   = pmr_pkg::PMR_ST_WARM;
          n.hold = 8'(RST_HOLD);
        end
      end
      pmr_pkg::PMR_ST_COLD, pmr_pkg::PMR_ST_WARM: begin
        if (warm_src) begin
          n.hold = 8'(RST_HOLD);
        end else if (r.hold == 8'h00) begin
          n.st = pmr_pkg::PMR_ST_RUN;
        end else begin
          n.hold = r.hold - 8'h01;
        end
      end
      default: n.st = pmr_pkg::PMR_ST_COLD;
    endcase
    if (cold_src) begin
      n.st   = pmr_pkg::PMR_ST_COLD;
      n.hold = 8'(RST_HOLD);
    end

    // Detector settle after enable
    n.en_seen = r.sag_en;
    if (!r.sag_en || !r.en_seen) begin
      n.settle  = 2'h0;
      n.settled = 1'b0;
    end else if (slow_osc_tick && !r.settled) begin
      // Wait for the third slow tick
      if (r.settle == 2'(`PMR_SETTLE_TICKS - 1)) begin
        n.settled = 1'b1;
      end else begin
        n.settle = r.settle + 2'h1;
      end
    end

    if (r.lp_sel == 2'b00) begin
      n.sample   = supply_below;
      n.sense_on = r.sag_en;
      n.lp_cnt   = 9'h000;
    end else if (slow_osc_tick) begin
      // Powered one slow tick per period
      if (r.sense_on) begin
        n.sample = supply_below;
      end
      if (r.lp_cnt >= pmr_lp_last(r.lp_sel)) begin
        n.lp_cnt   = 9'h000;
        n.sense_on = r.sag_en;
      end else begin
        n.lp_cnt   = r.lp_cnt + 9'h001;
        n.sense_on = 1'b0;
      end
    end

    n.live = live_n;
    if (cold_src || r.st != pmr_pkg::PMR_ST_RUN || warm_src) begin
      n.power_control_reg     = r.power_control_reg & `PMR_POWER_CONTROL_REG_RST;
      n.ta_open  = 1'b0;
      n.ta_stage = 1'b0;
      n.sag_en    = r.cfg[`PMR_CFG_EN];
      n.sag_thr   = r.cfg[`PMR_CFG_THR_HI:`PMR_CFG_THR_LO];
      n.sag_rsten = r.cfg[`PMR_CFG_RSTEN];
      // Flag reset value from config and supply
      n.sag_flag  = r.cfg[`PMR_CFG_EN] & ~r.cfg[`PMR_CFG_RSTEN] & supply_below;
      n.cause = n.cause | {sw_rst_req, wdt_rst_req, ext_rst_req};
    end
    if (cold_src || r.st == pmr_pkg::PMR_ST_COLD) begin
      n.power_control_reg     = `PMR_POWER_CONTROL_REG_RST;
      n.lp_sel   = SAG1_RST[`PMR_SAG1_LP_HI:`PMR_SAG1_LP_LO];
      n.flt_en   = SAG1_RST[`PMR_SAG1_FLT];
      n.cause    = 3'h0;
      n.sag_rstf = 1'b0;
    end

    // Unless reset enable turns it to reset
    if ((drop && !r.sag_rsten) || rec) begin
      n.sag_flag = 1'b1;
    end
    // Sag reset flag, set wins over clear except against a power-on class source
    if (drop && r.sag_rsten && !cold_src) begin
      n.sag_rstf = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= CORE_RST;
    end else begin
      r <= n;
    end
  end

  assign prdata  = {24'h000000, r.rdata};
  assign pready  = 1'b1;
  assign pslverr = access & ~hit;

  // CPU released only in run state
  assign cpu_rst_n    = (r.st == pmr_pkg::PMR_ST_RUN);
  assign osc_start    = r.osc_en;
  assign reset_vector = `PMR_RESET_VECTOR;
  assign sag_sense_on = r.sense_on;
  assign sag_threshold_select = r.sag_thr;
  assign sag_irq_req  = r.sag_flag;
  assign por_circuit_off = por_killed;
  assign lvr_circuit_off = lvr_killed;

endmodule // pmr_power_reset_ctrl

/* File: tb/pmr_power_reset_ctrl_asserts.sv */
`timescale 1ns/100ps
module pmr_power_reset_ctrl_asserts #(
  parameter int ADDR_W   = 10,
  parameter int RST_HOLD = 16
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              por_supply_low,
  input wire logic              lvr_supply_low,
  input wire logic              ext_rst_req,
  input wire logic              wdt_rst_req,
  input wire logic              sw_rst_req,
  input wire logic              cpu_rst_n,
  input wire logic              osc_start,
  input wire logic [15:0]       reset_vector,
  input wire logic              por_circuit_off,
  input wire logic              lvr_circuit_off
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] quiet_q;
  logic       src_any;
  // Visible sources only; a sag reset just lengthens the quiet run
  assign src_any = ext_rst_req | wdt_rst_req | sw_rst_req
                 | (por_supply_low & ~por_circuit_off) | (lvr_supply_low & ~lvr_circuit_off);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_q <= 8'h00;
    else if (src_any) quiet_q <= 8'h00;
    else if (quiet_q != 8'hFF) quiet_q <= quiet_q + 8'h01;
  end
  vector_zero_a: assert property (reset_vector == 16'h0000)
    else $error("reset vector not zero");
  osc_follows_a: assert property ($rose(cpu_rst_n) |=> osc_start)
    else $error("oscillator start missing after release");
  por_hold_a: assert property (por_supply_low && !por_circuit_off |=> !cpu_rst_n)
    else $error("cpu not held while power-on supply low");
  lvr_hold_a: assert property (lvr_supply_low && !lvr_circuit_off |=> !cpu_rst_n)
    else $error("cpu not held while low-voltage supply low");
  src_reset_a: assert property (ext_rst_req || wdt_rst_req || sw_rst_req |=> !cpu_rst_n)
    else $error("reset request did not reset cpu");
  release_gap_a: assert property ($rose(cpu_rst_n) |-> quiet_q >= RST_HOLD)
    else $error("cpu released too early");
  por_kill_a: assert property ($rose(por_circuit_off) |->
    $past(psel && penable && pwrite && paddr == 10'h3F4 && pwdata[7:0] == 8'hA5))
    else $error("power-on detector killed without second key");
  lvr_kill_a: assert property ($rose(lvr_circuit_off) |->
    $past(psel && penable && pwrite && paddr == 10'h3FC && pwdata[7:0] == 8'hA5))
    else $error("low-voltage detector killed without second key");
endmodule // pmr_power_reset_ctrl_asserts

bind pmr_power_reset_ctrl pmr_power_reset_ctrl_asserts #(
  .ADDR_W(ADDR_W), .RST_HOLD(RST_HOLD)
) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .por_supply_low(por_supply_low),
  .lvr_supply_low(lvr_supply_low), .ext_rst_req(ext_rst_req), .wdt_rst_req(wdt_rst_req),
  .sw_rst_req(sw_rst_req), .cpu_rst_n(cpu_rst_n), .osc_start(osc_start),
  .reset_vector(reset_vector), .por_circuit_off(por_circuit_off),
  .lvr_circuit_off(lvr_circuit_off)
);

/* File: tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
  localparam int HOLD = 2;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        por_low = 1'b0;
  logic        lvr_low = 1'b0;
  logic        ext_req = 1'b0;
  logic        wdt_req = 1'b0;
  logic        sw_req = 1'b0;
  logic        below = 1'b0;
  logic        tick = 1'b0;
  logic        pdown = 1'b0;
  logic [2:0]  tick_cnt = 3'h0;
  logic        cpu_rst_n;
  logic        osc_start;
  logic [15:0] vec;
  logic        sense_on;
  logic [2:0]  thr_sel;
  logic        irq;
  logic        por_off;
  logic        lvr_off;
  int          failures = 0;
  int          checks_done = 0;
  int          seed = 15;
  int          n;
  int          t;
  logic [31:0] v;
  logic [7:0]  q;
  logic        e;

  pmr_power_reset_ctrl #(.ADDR_W(10), .RST_HOLD(HOLD)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .por_supply_low(por_low), .lvr_supply_low(lvr_low),
    .ext_rst_req(ext_req), .wdt_rst_req(wdt_req), .sw_rst_req(sw_req),
    .supply_below(below), .slow_osc_tick(tick), .sys_clk_fast_src(1'b1),
    .power_down(pdown), .cpu_rst_n(cpu_rst_n), .osc_start(osc_start),
    .reset_vector(vec), .sag_sense_on(sense_on), .sag_threshold_select(thr_sel),
    .sag_irq_req(irq), .por_circuit_off(por_off), .lvr_circuit_off(lvr_off)
  );

  always #2 pclk = ~pclk;
  // Slow oscillator shortened to one tick per 8 pclk
  always @(posedge pclk) begin
    tick_cnt <= tick_cnt + 3'h1;
    tick     <= (tick_cnt == 3'h7);
  end

  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata[7:0];
    e = pslverr;
    if (k >= 50) failures++;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Step off the edge so callers see the registers it updated
    #1;
  endtask
  task automatic pw(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, 8'hC7, 8'hAA);
    xfer(1'b1, 8'hC7, 8'h55);
    xfer(1'b1, idx, d);
  endtask
  task automatic rd(string nm, logic [7:0] idx, logic [7:0] exp, logic [7:0] m = 8'hFF);
    xfer(1'b0, idx, 8'h00);
    check(nm, q & m, exp);
  endtask
  task automatic wait_run();
    n = 0;
    while (cpu_rst_n !== 1'b1 && n < 500) begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (n >= 500) failures++;
  endtask
  task automatic glitch();
    @(posedge pclk) below <= 1'b1;
    repeat (10) @(posedge pclk);
    below <= 1'b0;
    repeat (80) @(posedge pclk);
  endtask
  task automatic settle(logic lvl);
    @(posedge pclk) below <= lvl;
    repeat (80) @(posedge pclk);
  endtask

  initial begin
    #(4 * 40000);
    failures++;
    stop_test();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    wait_run();
    check("hold", n, HOLD + 1);
    check("vector", vec, 16'h0000);
    rd("power_control_reg", 8'h87, 8'h10);
    rd("cfg", 8'h90, 8'hFF);
    rd("sag1", 8'hAB, 8'h01);
    rd("sag0", 8'hA3, 8'hF4);
    check("thr", thr_sel, 3'b111);
    rd("unmapped", 8'h00, 8'h00);
    check("slverr", e, 1'b1);
    repeat (3) begin
      v = $random(seed) & 32'hFC;
      xfer(1'b1, 8'h87, v[7:0]);
      rd("power_control_reg_rw", 8'h87, v[7:0]);
    end
    xfer(1'b1, 8'hAB, 8'h00);
    rd("sag1_lock", 8'hAB, 8'h01);
    pw(8'hAB, 8'h00);
    rd("sag1_open", 8'hAB, 8'h00);
    xfer(1'b1, 8'hAB, 8'h01);
    rd("sag1_closed", 8'hAB, 8'h00);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, 8'h87, 8'hEC);
      @(posedge pclk) {sw_req, wdt_req, ext_req} <= 3'b001 << i;
      @(posedge pclk) {sw_req, wdt_req, ext_req} <= 3'b000;
      #1 check("src_rst", cpu_rst_n, 1'b0);
      wait_run();
      rd("power_control_reg_warm", 8'h87, 8'h00);
      rd("sag1_warm", 8'hAB, 8'h00);
      rd("cause", 8'h91, 8'h01 << i, 8'h01 << i);
    end
    @(posedge pclk) por_low <= 1'b1;
    repeat (5) @(posedge pclk);
    por_low <= 1'b0;
    wait_run();
    rd("power_control_reg_cold", 8'h87, 8'h10);
    rd("sag1_cold", 8'hAB, 8'h01);
    for (int k = 0; k < 4; k++) begin
      pw(8'hA3, {2'b10, k[1:0], 4'h4});
      check("thr_sw", thr_sel, {1'b0, k[1:0]});
    end
    pw(8'hA3, 8'hF0);
    glitch();
    rd("filtered", 8'hA3, 8'hF0);
    settle(1'b1);
    rd("drop", 8'hA3, 8'hF9);
    check("irq", irq, 1'b1);
    check("no_reset", cpu_rst_n, 1'b1);
    pw(8'hA3, 8'hF0);
    repeat (80) @(posedge pclk);
    rd("no_reset_flag", 8'hA3, 8'hF1);
    settle(1'b0);
    rd("recover", 8'hA3, 8'hF8);
    // Power-down forces the two-tick filter: 26 cycles pass it, 32 fast would not
    @(posedge pclk) pdown <= 1'b1;
    pw(8'hA3, 8'hF0);
    @(posedge pclk) below <= 1'b1;
    repeat (26) @(posedge pclk);
    below <= 1'b0;
    repeat (80) @(posedge pclk);
    rd("slow_filter", 8'hA3, 8'hF8);
    @(posedge pclk) pdown <= 1'b0;
    pw(8'hAB, 8'h00);
    pw(8'hA3, 8'hF0);
    glitch();
    rd("unfiltered", 8'hA3, 8'hF8);
    @(posedge pclk) below <= 1'b1;
    pw(8'hA3, 8'h70);
    rd("disabled", 8'hA3, 8'h70);
    pw(8'hA3, 8'hF0);
    rd("settling", 8'hA3, 8'hF0);
    settle(1'b0);
    pw(8'hA3, 8'hF4);
    @(posedge pclk) below <= 1'b1;
    n = 0;
    while (cpu_rst_n !== 1'b0 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    check("sag_rst", cpu_rst_n, 1'b0);
    below <= 1'b0;
    wait_run();
    rd("rst_flag", 8'hA3, 8'hF6, 8'hF7);
    pw(8'hA3, 8'hF4);
    rd("rst_flag_clr", 8'hA3, 8'hF4, 8'hF7);
    for (int c = 0; c < 4; c++) begin
      pw(8'hAB, {5'h0, c[1:0], 1'b1});
      t = 0;
      n = 0;
      for (int k = 0; k < 2 && c > 0; k++) begin
        t = 0;
        while (sense_on !== 1'b0 && n < 9000) begin
          @(posedge pclk);
          n++;
          if (tick) t++;
        end
        while (sense_on !== 1'b1 && n < 9000) begin
          @(posedge pclk);
          n++;
          if (tick) t++;
        end
      end
      repeat (100 * (c == 0)) begin
        @(posedge pclk);
        if (sense_on !== 1'b1) t++;
      end
      check("period", t, (c == 0) ? 0 : 16 << (2 * (c - 1)));
    end
    for (int j = 0; j < 2; j++) begin
      pw(8'hFD + 2 * j, 8'h5A);
      pw(8'hFD + 2 * j, 8'h33);
      pw(8'hFD + 2 * j, 8'hA5);
      check("kill_broken", j ? lvr_off : por_off, 1'b0);
      pw(8'hFD + 2 * j, 8'h5A);
      pw(8'hFD + 2 * j, 8'hA5);
      check("kill", j ? lvr_off : por_off, 1'b1);
      @(posedge pclk) {lvr_low, por_low} <= 2'b01 << j;
      repeat (5) @(posedge pclk);
      check("killed_ignored", cpu_rst_n, 1'b1);
      {lvr_low, por_low} <= 2'b00;
    end
    stop_test();
  end
endmodule // testbench
